// file: logic/spc_top.sv
module spc_top
  import spc_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Serial port pins.
  input wire logic SCLK_I,
  input wire logic CS_B_I,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE_O,
  output logic SDO_O,
  output logic SDO_OE_O,
  // Configuration download.
  input wire logic NVM_EN_I,
  input wire logic PIN_PROG_EN_I,
  input wire logic DNLD_DONE_I,
  output logic DNLD_START_O,
  output logic SOFT_RST_O,
  // Non-volatile save port.
  input wire logic SAVE_RD_I,
  input wire logic [ADDR_W-1:0] SAVE_ADDR_I,
  output logic [7:0] SAVE_DATA_O,
  output logic SAVE_INCL_O,
  // Active settings.
  output logic UPDATE_O,
  output logic [8*BANK_N-1:0] ACTIVE_O
);

  spc_bank_if bus ();
  spc_bank spc_bank_inst (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .bus(bus)
  );

  // ==========================================================
  // Pin synchronisers: a level is accepted once stages two and three agree.
  logic [2:0] pin_in;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] lvl_q;
  assign pin_in = {SCLK_I, CS_B_I, SDIO_I};
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
        s1_q[g] <= SYNC_RST[g];
        s2_q[g] <= SYNC_RST[g];
        s3_q[g] <= SYNC_RST[g];
        lvl_q[g] <= SYNC_RST[g];
      end else begin
        s1_q[g] <= pin_in[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          lvl_q[g] <= s3_q[g];
        end
      end
    end
  end
  logic sclk_rise;
  logic sclk_fall;
  logic cs_low;
  logic sdi;
  assign sclk_rise = s2_q[2] & s3_q[2] & ~lvl_q[2];
  assign sclk_fall = ~s2_q[2] & ~s3_q[2] & lvl_q[2];
  assign cs_low = ~lvl_q[1];
  assign sdi = s3_q[0];

  // ==========================================================
  // Control registers.
  logic cfg_sdo_q;
  logic cfg_lsb_q;
  logic srst_q;
  logic rb_sel_q;
  logic upd_q;

  // ==========================================================
  // Serial transfer state.
  spc_state_t state_q;
  logic [15:0] sh_q;
  logic [3:0] bcnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic rw_q;
  logic [1:0] len_q;
  logic [1:0] nby_q;
  logic [15:0] ins;
  logic [7:0] byte_in;
  logic [ADDR_W-1:0] addr_nxt;
  logic wr_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic rd_req_q;
  logic rd_pend_q;
  logic [ADDR_W-1:0] rd_addr_q;
  assign ins = cfg_lsb_q ? {sdi, sh_q[15:1]} : {sh_q[14:0], sdi};
  assign byte_in = cfg_lsb_q ? {sdi, sh_q[15:9]} : {sh_q[6:0], sdi};
  assign addr_nxt = cfg_lsb_q ? addr_q + 13'h0001 : addr_q - 13'h0001;
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q <= ST_IDLE;
      sh_q <= 16'h0000;
      bcnt_q <= 4'h0;
      addr_q <= CFG_ADDR;
      rw_q <= 1'b0;
      len_q <= 2'h0;
      nby_q <= 2'h0;
      wr_q <= 1'b0;
      wr_addr_q <= CFG_ADDR;
      wr_data_q <= 8'h00;
      rd_req_q <= 1'b0;
      rd_addr_q <= CFG_ADDR;
    end else begin
      wr_q <= 1'b0;
      rd_req_q <= 1'b0;
      if (!cs_low) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            state_q <= ST_INSTR;
            bcnt_q <= 4'h0;
          end
          ST_INSTR: begin
            if (sclk_rise) begin
              sh_q <= ins;
              bcnt_q <= bcnt_q + 4'h1;
              if (bcnt_q == INS_LAST) begin
                rw_q <= ins[INS_RW_BIT];
                len_q <= ins[INS_LEN_HI:INS_LEN_LO];
                addr_q <= ins[ADDR_W-1:0];
                rd_addr_q <= ins[ADDR_W-1:0];
                rd_req_q <= ins[INS_RW_BIT];
                nby_q <= 2'h0;
                bcnt_q <= 4'h0;
                state_q <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (sclk_rise) begin
              sh_q <= cfg_lsb_q ? {sdi, sh_q[15:1]} : {sh_q[14:0], sdi};
              bcnt_q <= bcnt_q + 4'h1;
              if (bcnt_q == BYTE_LAST) begin
                bcnt_q <= 4'h0;
                wr_q <= ~rw_q;
                wr_addr_q <= addr_q;
                wr_data_q <= byte_in;
                addr_q <= addr_nxt;
                rd_addr_q <= addr_nxt;
                nby_q <= nby_q + 2'h1;
                if (len_q != LEN_STREAM && nby_q == len_q) begin
                  state_q <= ST_DONE;
                end else begin
                  rd_req_q <= rw_q;
                end
              end
            end
          end
          ST_DONE: state_q <= ST_DONE;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Register writes and soft reset sequence.
  logic srst_go;
  logic [7:0] srst_cnt_q;
  logic dl_wait_q;
  assign srst_go = wr_q && wr_addr_q == CFG_ADDR && wr_data_q[CFG_SRST_BIT];
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg_sdo_q <= CFG_RST[CFG_SDO_BIT];
      cfg_lsb_q <= CFG_RST[CFG_LSB_BIT];
      rb_sel_q <= RB_RST[RB_SEL_BIT];
    end else if (srst_go) begin
      cfg_sdo_q <= CFG_RST[CFG_SDO_BIT];
      cfg_lsb_q <= CFG_RST[CFG_LSB_BIT];
      rb_sel_q <= RB_RST[RB_SEL_BIT];
    end else if (wr_q && wr_addr_q == CFG_ADDR) begin
      cfg_sdo_q <= wr_data_q[CFG_SDO_BIT];
      cfg_lsb_q <= wr_data_q[CFG_LSB_BIT];
    end else if (wr_q && wr_addr_q == RB_ADDR) begin
      rb_sel_q <= wr_data_q[RB_SEL_BIT];
    end
  end

  // The bit stays set until the timer ends and any started download reports done.
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      srst_q <= 1'b0;
      srst_cnt_q <= 8'h00;
      dl_wait_q <= 1'b0;
      DNLD_START_O <= 1'b0;
    end else begin
      DNLD_START_O <= 1'b0;
      if (srst_go) begin
        srst_q <= 1'b1;
        srst_cnt_q <= SRST_CYC;
        dl_wait_q <= NVM_EN_I | PIN_PROG_EN_I;
        DNLD_START_O <= NVM_EN_I | PIN_PROG_EN_I;
      end else begin
        if (srst_cnt_q != 8'h00) begin
          srst_cnt_q <= srst_cnt_q - 8'h01;
        end
        if (DNLD_DONE_I) begin
          dl_wait_q <= 1'b0;
        end
        if (srst_cnt_q == 8'h00 && (!dl_wait_q || DNLD_DONE_I)) begin
          srst_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= wr_q && wr_addr_q == UPD_ADDR && wr_data_q[UPD_BIT];
    end
  end
  assign bus.wr_en = wr_q && wr_addr_q[ADDR_W-1:BANK_IDX_W] == BANK_BASE[ADDR_W-1:BANK_IDX_W];
  assign bus.wr_idx = wr_addr_q[BANK_IDX_W-1:0];
  assign bus.wr_data = wr_data_q;
  assign bus.update = upd_q;
  assign bus.clr = srst_go;
  assign bus.rd_sel = rb_sel_q;
  assign bus.rd_idx = rd_addr_q[BANK_IDX_W-1:0];

  // ==========================================================
  // Readback path: bank data is ready one cycle after the request.
  logic [7:0] tx_q;
  logic [2:0] bi;
  assign bi = cfg_lsb_q ? bcnt_q[2:0] : 3'h7 - bcnt_q[2:0];
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rd_pend_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      rd_pend_q <= rd_req_q;
      if (rd_pend_q) begin
        if (rd_addr_q == CFG_ADDR) begin
          tx_q <= {cfg_sdo_q, cfg_lsb_q, srst_q, 5'h00};
        end else if (rd_addr_q == RB_ADDR) begin
          tx_q <= {7'h00, rb_sel_q};
        end else if (rd_addr_q[ADDR_W-1:BANK_IDX_W] == BANK_BASE[ADDR_W-1:BANK_IDX_W]) begin
          tx_q <= bus.rd_data;
        end else begin
          tx_q <= 8'h00;
        end
      end
    end
  end

  // SCLK half periods must span at least three clocks so data is loaded first.
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SDIO_O <= 1'b0;
      SDO_O <= 1'b0;
      SDIO_OE_O <= 1'b0;
      SDO_OE_O <= 1'b0;
    end else begin
      if (sclk_fall) begin
        SDIO_O <= tx_q[bi];
        SDO_O <= tx_q[bi];
      end
      SDIO_OE_O <= cs_low && state_q == ST_DATA && rw_q && !cfg_sdo_q;
      SDO_OE_O <= cs_low && state_q == ST_DATA && rw_q && cfg_sdo_q;
    end
  end

  // ==========================================================
  // Save port and outputs.
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SAVE_DATA_O <= 8'h00;
      SAVE_INCL_O <= 1'b0;
    end else if (SAVE_RD_I) begin
      SAVE_INCL_O <= SAVE_ADDR_I != CFG_ADDR;
      if (SAVE_ADDR_I == RB_ADDR) begin
        SAVE_DATA_O <= {7'h00, rb_sel_q};
      end else if (SAVE_ADDR_I[ADDR_W-1:BANK_IDX_W] == BANK_BASE[ADDR_W-1:BANK_IDX_W]) begin
        SAVE_DATA_O <= bus.act[8*SAVE_ADDR_I[BANK_IDX_W-1:0] +: 8];
      end else begin
        SAVE_DATA_O <= 8'h00;
      end
    end
  end

  assign SOFT_RST_O = srst_q;
  assign UPDATE_O = upd_q;
  assign ACTIVE_O = bus.act;
endmodule

// file: inc/spc_pkg.sv
// Functional notes
// - Data out pin driven only when bit7 set
// - Bit6 set: LSB first, address increments
// - Bit6 clear: MSB first, address decrements
// - Bit5 resets device, starts enabled download
// - Port configuration never included in saves
// - Readback select set: reads return buffered values
// - Readback select clear: reads return active values
// - Readback select acts at once, live
// - Update bit copies buffers to active, self-clears
package spc_pkg;

  // ==========================================================
  // Widths and instruction layout.
  localparam int ADDR_W = 13;
  localparam int BANK_N = 8;
  localparam int BANK_IDX_W = 3;
  localparam int INS_RW_BIT = 15;
  localparam int INS_LEN_HI = 14;
  localparam int INS_LEN_LO = 13;
  localparam logic [3:0] INS_LAST = 4'h0f;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  // ==========================================================
  // Register map.
  localparam logic [ADDR_W-1:0] CFG_ADDR = 13'h0000;
  localparam logic [ADDR_W-1:0] RB_ADDR = 13'h0004;
  localparam logic [ADDR_W-1:0] UPD_ADDR = 13'h0005;
  localparam logic [ADDR_W-1:0] BANK_BASE = 13'h0010;
  localparam int CFG_SDO_BIT = 7;
  localparam int CFG_LSB_BIT = 6;
  localparam int CFG_SRST_BIT = 5;
  localparam int RB_SEL_BIT = 0;
  localparam int UPD_BIT = 0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RB_RST = 8'h00;
  localparam logic [7:0] BANK_RST = 8'h00;

  // ==========================================================
  // Timing.
  localparam int CLK_PERIOD_NS = 8;
  localparam int SRST_TIME_NS = 80;
  localparam logic [7:0] SRST_CYC = 8'((SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Synchroniser reset levels for {sclk, cs_b, sdi}.
  localparam logic [2:0] SYNC_RST = 3'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_INSTR = 2'h1,
    ST_DATA = 2'h3,
    ST_DONE = 2'h2
  } spc_state_t;

endpackage

// file: inc/spc_bank_if.sv
interface spc_bank_if;
  import spc_pkg::*;
  logic wr_en;
  logic [BANK_IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic update;
  logic clr;
  logic rd_sel;
  logic [BANK_IDX_W-1:0] rd_idx;
  logic [7:0] rd_data;
  logic [8*BANK_N-1:0] act;
  modport ctrl (output wr_en, wr_idx, wr_data, update, clr, rd_sel, rd_idx,
                input rd_data, act);
  modport bank (input wr_en, wr_idx, wr_data, update, clr, rd_sel, rd_idx,
                output rd_data, act);
endinterface

// file: logic/spc_bank.sv
module spc_bank
  import spc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  spc_bank_if.bank bus
);

  logic [7:0] buf_q [BANK_N];
  logic [7:0] act_q [BANK_N];
  logic [7:0] rd_q;

  // ==========================================================
  // Buffered and active copies.
  for (genvar i = 0; i < BANK_N; i++) begin : g_ent
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        buf_q[i] <= BANK_RST;
      end else if (bus.clr) begin
        buf_q[i] <= BANK_RST;
      end else if (bus.wr_en && bus.wr_idx == BANK_IDX_W'(i)) begin
        buf_q[i] <= bus.wr_data;
      end
    end

    // A write in the same cycle as an update lands after it, on purpose.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        act_q[i] <= BANK_RST;
      end else if (bus.clr) begin
        act_q[i] <= BANK_RST;
      end else if (bus.update) begin
        act_q[i] <= buf_q[i];
      end
    end

    assign bus.act[8*i +: 8] = act_q[i];
  end

  // ==========================================================
  // Readback source follows the live select directly.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_q <= BANK_RST;
    end else if (bus.rd_sel) begin
      rd_q <= buf_q[bus.rd_idx];
    end else begin
      rd_q <= act_q[bus.rd_idx];
    end
  end

  assign bus.rd_data = rd_q;

endmodule

// file: verif/spc_host.sv
// ==========================================================
// Serial host model, mode 0, slow enough for the pin synchronisers.
module spc_host
  import spc_pkg::*;
(
  // Clock and mode.
  input wire logic clk_i,
  input wire logic lsb_i,
  input wire logic sdo_mode_i,
  // Serial pins.
  input wire logic sdio_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic cs_b_o,
  output logic sdio_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    sdio_o = 1'b0;
  end

  // A released line shows the inverse of its last value, never a stale copy.
  task automatic bitx(input logic b, input logic drv, output logic s);
    sdio_o = drv ? b : ~sdio_o;
    repeat (10) @(posedge clk_i);
    #1 s = sdo_mode_i ? sdo_i : sdio_i;
    sclk_o = 1'b1;
    repeat (10) @(posedge clk_i);
    #1 sclk_o = 1'b0;
  endtask

  task automatic frame(input logic [15:0] ins, input logic [15:0] wd,
                       input int n, output logic [15:0] rv);
    logic s;
    int j;
    rv = '0;
    @(posedge clk_i);
    #1 cs_b_o = 1'b0;
    for (int i = 0; i < 16; i++) begin
      bitx(ins[lsb_i ? i : 15 - i], 1'b1, s);
    end
    for (int i = 0; i < 8 * n; i++) begin
      j = 8 * (i / 8) + (lsb_i ? i % 8 : 7 - i % 8);
      bitx(wd[j], !ins[15], s);
      rv[j] = s;
    end
    repeat (10) @(posedge clk_i);
    #1 cs_b_o = 1'b1;
    sdio_o = ~sdio_o;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// file: verif/spc_top_props.sv
// ==========================================================
// Port checks of the serial configuration block.
module spc_top_props
  import spc_pkg::*;
(
  // Inputs watched.
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic CS_B_I,
  input wire logic NVM_EN_I,
  input wire logic PIN_PROG_EN_I,
  input wire logic DNLD_DONE_I,
  input wire logic SAVE_RD_I,
  input wire logic [ADDR_W-1:0] SAVE_ADDR_I,
  // Outputs watched.
  input wire logic SDIO_OE_O,
  input wire logic SDO_OE_O,
  input wire logic DNLD_START_O,
  input wire logic SOFT_RST_O,
  input wire logic SAVE_INCL_O,
  input wire logic UPDATE_O,
  input wire logic [8*BANK_N-1:0] ACTIVE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  property p_oe_excl; SDO_OE_O |-> !SDIO_OE_O; endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("both data pins driven");
  property p_cs_idle; CS_B_I [*8] |-> !SDIO_OE_O && !SDO_OE_O; endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("pin driven while idle");
  property p_save0; SAVE_RD_I && SAVE_ADDR_I == CFG_ADDR |=> !SAVE_INCL_O; endproperty
  a_save0: assert property (p_save0) else $error("config offered for save");
  property p_save1; SAVE_RD_I && SAVE_ADDR_I != CFG_ADDR |=> SAVE_INCL_O; endproperty
  a_save1: assert property (p_save1) else $error("address left out of save");
  property p_upd; UPDATE_O |=> !UPDATE_O; endproperty
  a_upd: assert property (p_upd) else $error("update pulse too long");
  property p_dnld;
    DNLD_START_O |-> $past(NVM_EN_I || PIN_PROG_EN_I) && SOFT_RST_O;
  endproperty
  a_dnld: assert property (p_dnld) else $error("download start unexpected");
  property p_srst10; $rose(SOFT_RST_O) |-> SOFT_RST_O [*8] ##1 SOFT_RST_O ##1 SOFT_RST_O;
  endproperty
  a_srst10: assert property (p_srst10) else $error("soft reset too short");
  property p_srst_end; SOFT_RST_O && DNLD_DONE_I |-> ##[1:20] !SOFT_RST_O; endproperty
  a_srst_end: assert property (p_srst_end) else $error("soft reset stuck");
  property p_active;
    !$stable(ACTIVE_O) |-> UPDATE_O || $past(UPDATE_O) || SOFT_RST_O || $past(SOFT_RST_O);
  endproperty
  a_active: assert property (p_active) else $error("active moved alone");

  c_sdo: cover property ($rose(SDO_OE_O));
  c_upd: cover property ($rose(UPDATE_O));
  c_dnld: cover property (DNLD_START_O);
endmodule

bind spc_top spc_top_props spc_top_props_inst (
  .CLK_I(CLK_I),
  .RST_B_I(RST_B_I),
  .CS_B_I(CS_B_I),
  .NVM_EN_I(NVM_EN_I),
  .PIN_PROG_EN_I(PIN_PROG_EN_I),
  .DNLD_DONE_I(DNLD_DONE_I),
  .SAVE_RD_I(SAVE_RD_I),
  .SAVE_ADDR_I(SAVE_ADDR_I),
  .SDIO_OE_O(SDIO_OE_O),
  .SDO_OE_O(SDO_OE_O),
  .DNLD_START_O(DNLD_START_O),
  .SOFT_RST_O(SOFT_RST_O),
  .SAVE_INCL_O(SAVE_INCL_O),
  .UPDATE_O(UPDATE_O),
  .ACTIVE_O(ACTIVE_O)
);

// file: verif/serial_port_config_readback_tb.sv
module serial_port_config_readback_tb
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, nvm = 1'b0, pin = 1'b0, done = 1'b0;
  logic save_rd = 1'b0, lsb = 1'b0, sdo = 1'b0;
  logic [ADDR_W-1:0] save_a = '0;
  logic [7:0] rv;
  logic sclk, cs_b, host_d, sdio_w, sdio_o, sdio_oe, sdo_o, sdo_oe, sdo_w;
  logic dnld, srst, incl, upd;
  logic [7:0] sdat;
  logic [8*BANK_N-1:0] act;
  int num_errors = 0, checked = 0, dnld_n = 0;

  always #4 clk = ~clk;
  // The device wins the shared data line whenever it enables it.
  assign sdio_w = sdio_oe ? sdio_o : host_d;
  // A disabled data out pin shows the opposite of the driven bit, so a missing enable fails.
  assign sdo_w = sdo_oe ? sdo_o : ~sdo_o;
  always @(posedge clk) if (dnld === 1'b1) dnld_n <= dnld_n + 1;

  spc_host spc_host_inst (.clk_i(clk), .lsb_i(lsb), .sdo_mode_i(sdo), .sdio_i(sdio_w),
    .sdo_i(sdo_w), .sclk_o(sclk), .cs_b_o(cs_b), .sdio_o(host_d));
  spc_top spc_top_inst (.CLK_I(clk), .RST_B_I(rst_b), .SCLK_I(sclk), .CS_B_I(cs_b),
    .SDIO_I(sdio_w), .SDIO_O(sdio_o), .SDIO_OE_O(sdio_oe), .SDO_O(sdo_o),
    .SDO_OE_O(sdo_oe), .NVM_EN_I(nvm), .PIN_PROG_EN_I(pin), .DNLD_DONE_I(done),
    .DNLD_START_O(dnld), .SOFT_RST_O(srst), .SAVE_RD_I(save_rd), .SAVE_ADDR_I(save_a),
    .SAVE_DATA_O(sdat), .SAVE_INCL_O(incl), .UPDATE_O(upd), .ACTIVE_O(act));

  // ==========================================================
  // Shared helpers.
  task chk(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task conclude;
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [12:0] a, input logic [15:0] d, input int n);
    logic [15:0] x;
    spc_host_inst.frame({1'b0, 2'(n - 1), a}, d, n, x);
  endtask
  task rd(input logic [12:0] a);
    logic [15:0] x;
    spc_host_inst.frame({1'b1, 2'h0, a}, 16'h0000, 1, x);
    rv = x[7:0];
  endtask

  // ==========================================================
  // Scenarios.
  task t_reset;
    chk({srst, upd}, 2'h0);
    chk(act, '0);
    rd(CFG_ADDR);
    chk(rv, 8'h00);
    rd(RB_ADDR);
    chk(rv, 8'h00);
  endtask
  task t_buf;
    wr(13'h0010, 16'h005a, 1);
    rd(13'h0010);
    chk(rv, 8'h00);
    wr(RB_ADDR, 16'h0001, 1);
    rd(13'h0010);
    chk(rv, 8'h5a);
    chk(act[7:0], 8'h00);
    wr(UPD_ADDR, 16'h0001, 1);
    chk(act[7:0], 8'h5a);
    rd(UPD_ADDR);
    chk(rv, 8'h00);
    wr(RB_ADDR, 16'h0000, 1);
  endtask
  task t_msb;
    logic [15:0] x;
    wr(13'h0013, 16'h2211, 2);
    spc_host_inst.frame({1'b0, LEN_STREAM, 13'h0017}, 16'h6655, 2, x);
    wr(UPD_ADDR, 16'h0001, 1);
    chk(act[31:16], 16'h1122);
    chk(act[63:48], 16'h5566);
  endtask
  task t_lsb;
    wr(CFG_ADDR, 16'h0040, 1);
    lsb = 1'b1;
    wr(13'h0014, 16'h4433, 2);
    wr(UPD_ADDR, 16'h0001, 1);
    chk(act[47:32], 16'h4433);
    rd(CFG_ADDR);
    chk(rv, 8'h40);
    wr(CFG_ADDR, 16'h00c0, 1);
    sdo = 1'b1;
    rd(13'h0015);
    chk(rv, 8'h44);
  endtask
  task t_save(input logic [12:0] a, input logic e_incl, input logic [7:0] e_dat);
    @(posedge clk);
    #1 save_rd = 1'b1;
    save_a = a;
    @(posedge clk);
    #1 save_rd = 1'b0;
    @(posedge clk);
    #1 chk({incl, sdat}, {e_incl, e_dat});
  endtask
  task t_srst(input logic nv, input logic pp);
    int i;
    int n0;
    n0 = dnld_n;
    @(posedge clk);
    #1 nvm = nv;
    pin = pp;
    wr(CFG_ADDR, 16'h0020, 1);
    chk(srst, nv | pp);
    chk(64'(dnld_n - n0), 64'(nv | pp));
    chk(act, '0);
    @(posedge clk);
    #1 done = 1'b1;
    @(posedge clk);
    #1 done = 1'b0;
    for (i = 0; i < 40 && srst !== 1'b0; i++) @(posedge clk);
    if (srst !== 1'b0) begin
      num_errors++;
      conclude;
    end
    #1 lsb = 1'b0;
    sdo = 1'b0;
    rd(CFG_ADDR);
    chk(rv, 8'h00);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_buf;
    t_msb;
    t_lsb;
    t_save(CFG_ADDR, 1'b0, 8'h00);
    t_save(13'h0014, 1'b1, 8'h33);
    t_srst(1'b1, 1'b0);
    t_srst(1'b0, 1'b1);
    t_srst(1'b0, 1'b0);
    conclude;
  end
endmodule
